// ==== rtl/mie_consts.svh ====
// offsets, field positions, reset values and cycle counts of the execute block
`ifndef MIE_CONSTS_SVH
`define MIE_CONSTS_SVH

`define MIE_OFS_CMD 8'h00
`define MIE_OFS_STATUS 8'h04
`define MIE_OFS_ACC 8'h08
`define MIE_OFS_FLAGS 8'h0C
`define MIE_OFS_IMM 8'h10
`define MIE_OFS_SECTION 8'h14
`define MIE_OFS_TBL_LOW 8'h18
`define MIE_OFS_TBL_HIGH 8'h1C
`define MIE_OFS_TBL_LATCH 8'h20
`define MIE_OFS_DMEM_ADDR 8'h24
`define MIE_OFS_DMEM_DATA 8'h28
`define MIE_OFS_PMEM_ADDR 8'h2C
`define MIE_OFS_PMEM_DATA 8'h30

`define MIE_CMD_OP_LSB 0
`define MIE_CMD_DST_BIT 5
`define MIE_CMD_EXT_BIT 6
`define MIE_CMD_BIT_LSB 7
`define MIE_CMD_OFS_LSB 10
`define MIE_CMD_SEC_LSB 18

`define MIE_STAT_BUSY_BIT 0
`define MIE_STAT_SKIP_BIT 1
`define MIE_STAT_CYC_LSB 2

`define MIE_RST_BYTE 8'h00
`define MIE_RST_WORD 32'h0000_0000
`define MIE_RST_FLAGS 5'h00

`define MIE_CYC_PLAIN 2'h1
`define MIE_CYC_LONG 2'h2

`define MIE_DAA_LO 8'h06
`define MIE_DAA_HI 8'h60
`define MIE_NIBBLE_MAX 4'h9

`endif

// ==== rtl/mie_pkg.sv ====
// types of the execute block
package mie_pkg;

  typedef enum logic [4:0] {
    OP_COPY_SKIP_IF_ZERO = 5'h00,
    OP_SKIP_IF_BIT_CLEAR = 5'h01,
    OP_TABLE_READ_PAGED = 5'h02,
    OP_TABLE_READ_LAST_PAGE = 5'h03,
    OP_INC_TABLE_READ_PAGED = 5'h04,
    OP_INC_TABLE_READ_LAST_PAGE = 5'h05,
    OP_XOR_TO_ACC = 5'h06,
    OP_XOR_TO_MEMORY = 5'h07,
    OP_XOR_IMMEDIATE = 5'h08,
    OP_EXT_ADD_WITH_CARRY = 5'h09,
    OP_EXT_ADD = 5'h0A,
    OP_EXT_AND = 5'h0B,
    OP_EXT_OR = 5'h0C,
    OP_EXT_CLEAR = 5'h0D,
    OP_EXT_CLEAR_BIT = 5'h0E,
    OP_EXT_COMPLEMENT = 5'h0F,
    OP_EXT_DECIMAL_ADJUST = 5'h10,
    OP_EXT_DECREMENT = 5'h11,
    OP_EXT_INCREMENT = 5'h12,
    OP_EXT_MOVE_TO_ACC = 5'h13,
    OP_EXT_MOVE_TO_MEM = 5'h14
  } mie_op_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_WAIT = 2'b10
  } mie_state_type;

  typedef struct packed {
    logic signed_compare_flag;
    logic overflow_flag;
    logic zero_flag;
    logic aux_carry_flag;
    logic carry_flag;
  } mie_flags_type;

  typedef struct packed {
    mie_op_type op;
    logic dst_mem;
    logic ext;
    logic [2:0] bit_sel;
    logic [7:0] offset;
  } mie_cmd_type;

endpackage : mie_pkg

// ==== rtl/mie_execute.sv ====
// instruction execute unit with data and program memory behind an ahb-lite slave
`timescale 1ns/1ps
`include "mie_consts.svh"

module mie_execute #(
  parameter int DSEC_W = 1,
  parameter int TBH_W = 4
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata
);

  localparam int DA_W = DSEC_W + 8;
  localparam int PA_W = TBH_W + 8;

  ////////////////////////////////////////////////////////////////////////////
  // functions

  function automatic logic reg_is(input logic [7:0] a, input logic [7:0] o);
    return a == o;
  endfunction : reg_is

  function automatic mie_pkg::mie_cmd_type decode_cmd(input logic [31:0] w);
    mie_pkg::mie_cmd_type d;
    d.op = mie_pkg::mie_op_type'(w[`MIE_CMD_OP_LSB +: 5]);
    d.dst_mem = w[`MIE_CMD_DST_BIT];
    d.ext = w[`MIE_CMD_EXT_BIT];
    d.bit_sel = w[`MIE_CMD_BIT_LSB +: 3];
    d.offset = w[`MIE_CMD_OFS_LSB +: 8];
    return d;
  endfunction : decode_cmd

  ////////////////////////////////////////////////////////////////////////////
  // state

  mie_pkg::mie_state_type state;
  mie_pkg::mie_state_type next_state;
  mie_pkg::mie_flags_type flags;
  mie_pkg::mie_cmd_type cmd;
  logic [1:0] remain;
  logic [31:0] cmd_word;
  logic [7:0] accumulator_reg;
  logic [7:0] imm_reg;
  logic [7:0] table_pointer_low;
  logic [TBH_W-1:0] table_pointer_high;
  logic [7:0] table_high_latch;
  logic [DSEC_W-1:0] section_reg;
  logic skip_taken;
  logic [1:0] last_cycles;
  logic [DA_W-1:0] dmem_ptr;
  logic [PA_W-1:0] pmem_ptr;
  logic [7:0] dmem [2**DA_W];
  logic [15:0] pmem [2**PA_W];
  logic wr_pend;
  logic rd_wait;
  logic [7:0] pend_addr;
  logic next_rd_wait;
  logic next_hreadyout;
  logic [31:0] rd_val;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  wire accept = hsel && hready && htrans[1];
  wire commit = wr_pend && hreadyout;
  wire load_rd = rd_wait && (state == mie_pkg::ST_IDLE);
  wire wr_cmd = commit && reg_is(pend_addr, `MIE_OFS_CMD);
  wire wr_acc = commit && reg_is(pend_addr, `MIE_OFS_ACC);
  wire wr_flags = commit && reg_is(pend_addr, `MIE_OFS_FLAGS);
  wire wr_imm = commit && reg_is(pend_addr, `MIE_OFS_IMM);
  wire wr_sec = commit && reg_is(pend_addr, `MIE_OFS_SECTION);
  wire wr_tlow = commit && reg_is(pend_addr, `MIE_OFS_TBL_LOW);
  wire wr_thigh = commit && reg_is(pend_addr, `MIE_OFS_TBL_HIGH);
  wire wr_daddr = commit && reg_is(pend_addr, `MIE_OFS_DMEM_ADDR);
  wire wr_ddata = commit && reg_is(pend_addr, `MIE_OFS_DMEM_DATA);
  wire wr_paddr = commit && reg_is(pend_addr, `MIE_OFS_PMEM_ADDR);
  wire wr_pdata = commit && reg_is(pend_addr, `MIE_OFS_PMEM_DATA);
  wire exec = (state == mie_pkg::ST_EXEC);

  ////////////////////////////////////////////////////////////////////////////
  // operand fetch

  assign cmd = decode_cmd(cmd_word);
  wire op_ext = cmd.ext || (cmd.op >= mie_pkg::OP_EXT_ADD_WITH_CARRY);
  // extended forms carry their own section, ordinary ones use the selected one
  wire [DSEC_W-1:0] sec_use = op_ext ? cmd_word[`MIE_CMD_SEC_LSB +: DSEC_W] : section_reg;
  wire [DA_W-1:0] daddr = {sec_use, cmd.offset};
  wire [7:0] mem_rd = dmem[daddr];
  wire mem_bit = mem_rd[cmd.bit_sel];

  wire inc_tbl = (cmd.op == mie_pkg::OP_INC_TABLE_READ_PAGED) ||
                 (cmd.op == mie_pkg::OP_INC_TABLE_READ_LAST_PAGE);
  wire last_pg = (cmd.op == mie_pkg::OP_TABLE_READ_LAST_PAGE) ||
                 (cmd.op == mie_pkg::OP_INC_TABLE_READ_LAST_PAGE);
  // incremented pointer feeds the fetch in the same cycle
  wire [7:0] table_pointer_low_use = inc_tbl ? table_pointer_low + 8'h01 : table_pointer_low;
  wire [TBH_W-1:0] page = last_pg ? {TBH_W{1'b1}} : table_pointer_high;
  wire [15:0] pword = pmem[{page, table_pointer_low_use}];

  ////////////////////////////////////////////////////////////////////////////
  // arithmetic

  wire cin = (cmd.op == mie_pkg::OP_EXT_ADD_WITH_CARRY) && flags.carry_flag;
  wire [8:0] sum9 = {1'b0, accumulator_reg} + {1'b0, mem_rd} + {8'h00, cin};
  wire [4:0] sum_lo = {1'b0, accumulator_reg[3:0]} + {1'b0, mem_rd[3:0]} + {4'h0, cin};
  wire [7:0] sum_7 = {1'b0, accumulator_reg[6:0]} + {1'b0, mem_rd[6:0]} + {7'h00, cin};
  wire add_ov = sum9[8] ^ sum_7[7];
  wire add_sc = add_ov ^ sum9[7];

  wire lo_adj = (accumulator_reg[3:0] > `MIE_NIBBLE_MAX) || flags.aux_carry_flag;
  wire hi_adj = (accumulator_reg[7:4] > `MIE_NIBBLE_MAX) || flags.carry_flag;
  wire [7:0] daa_add = (lo_adj ? `MIE_DAA_LO : 8'h00) | (hi_adj ? `MIE_DAA_HI : 8'h00);
  wire [8:0] daa_sum = {1'b0, accumulator_reg} + {1'b0, daa_add};
  // carry only ever rises here, so chained bcd adds keep the earlier carry
  wire daa_c = flags.carry_flag | hi_adj | daa_sum[8];

  ////////////////////////////////////////////////////////////////////////////
  // result select

  logic [7:0] res;
  logic to_acc;
  logic to_mem;
  logic upd_z;
  logic upd_arith;
  logic upd_daa;
  logic skip_now;
  logic tbl_op;

  always_comb begin
    res = mem_rd;
    to_acc = 1'b0;
    to_mem = 1'b0;
    upd_z = 1'b0;
    upd_arith = 1'b0;
    upd_daa = 1'b0;
    skip_now = 1'b0;
    tbl_op = 1'b0;
    case (cmd.op)
      mie_pkg::OP_COPY_SKIP_IF_ZERO: begin
        to_acc = 1'b1;
        skip_now = (mem_rd == 8'h00);
      end
      mie_pkg::OP_SKIP_IF_BIT_CLEAR: begin
        skip_now = !mem_bit;
      end
      mie_pkg::OP_TABLE_READ_PAGED, mie_pkg::OP_TABLE_READ_LAST_PAGE,
      mie_pkg::OP_INC_TABLE_READ_PAGED, mie_pkg::OP_INC_TABLE_READ_LAST_PAGE: begin
        res = pword[7:0];
        to_mem = 1'b1;
        tbl_op = 1'b1;
      end
      mie_pkg::OP_XOR_TO_ACC: begin
        res = accumulator_reg ^ mem_rd;
        to_acc = 1'b1;
        upd_z = 1'b1;
      end
      mie_pkg::OP_XOR_TO_MEMORY: begin
        res = accumulator_reg ^ mem_rd;
        to_mem = 1'b1;
        upd_z = 1'b1;
      end
      mie_pkg::OP_XOR_IMMEDIATE: begin
        res = accumulator_reg ^ imm_reg;
        to_acc = 1'b1;
        upd_z = 1'b1;
      end
      mie_pkg::OP_EXT_ADD_WITH_CARRY, mie_pkg::OP_EXT_ADD: begin
        res = sum9[7:0];
        to_acc = !cmd.dst_mem;
        to_mem = cmd.dst_mem;
        upd_arith = 1'b1;
      end
      mie_pkg::OP_EXT_AND: begin
        res = accumulator_reg & mem_rd;
        to_acc = !cmd.dst_mem;
        to_mem = cmd.dst_mem;
        upd_z = 1'b1;
      end
      mie_pkg::OP_EXT_OR: begin
        res = accumulator_reg | mem_rd;
        to_acc = !cmd.dst_mem;
        to_mem = cmd.dst_mem;
        upd_z = 1'b1;
      end
      mie_pkg::OP_EXT_CLEAR: begin
        res = 8'h00;
        to_mem = 1'b1;
      end
      mie_pkg::OP_EXT_CLEAR_BIT: begin
        res = mem_rd & ~(8'h01 << cmd.bit_sel);
        to_mem = 1'b1;
      end
      mie_pkg::OP_EXT_COMPLEMENT: begin
        res = ~mem_rd;
        to_acc = !cmd.dst_mem;
        to_mem = cmd.dst_mem;
        upd_z = 1'b1;
      end
      mie_pkg::OP_EXT_DECIMAL_ADJUST: begin
        res = daa_sum[7:0];
        to_mem = 1'b1;
        upd_daa = 1'b1;
      end
      mie_pkg::OP_EXT_DECREMENT: begin
        res = mem_rd - 8'h01;
        to_acc = !cmd.dst_mem;
        to_mem = cmd.dst_mem;
        upd_z = 1'b1;
      end
      mie_pkg::OP_EXT_INCREMENT: begin
        res = mem_rd + 8'h01;
        to_acc = !cmd.dst_mem;
        to_mem = cmd.dst_mem;
        upd_z = 1'b1;
      end
      mie_pkg::OP_EXT_MOVE_TO_ACC: begin
        to_acc = 1'b1;
      end
      mie_pkg::OP_EXT_MOVE_TO_MEM: begin
        res = accumulator_reg;
        to_mem = 1'b1;
      end
      default: begin
        res = mem_rd;
      end
    endcase
  end

  // long forms take one cycle more; a taken skip adds the dummy cycle
  wire [1:0] cyc_base = (op_ext || tbl_op) ? `MIE_CYC_LONG : `MIE_CYC_PLAIN;
  wire [1:0] cyc_now = cyc_base + {1'b0, skip_now};

  ////////////////////////////////////////////////////////////////////////////
  // sequencing

  always_comb begin
    next_state = state;
    case (state)
      mie_pkg::ST_IDLE: next_state = wr_cmd ? mie_pkg::ST_EXEC : mie_pkg::ST_IDLE;
      mie_pkg::ST_EXEC: next_state = (cyc_now == `MIE_CYC_PLAIN) ? mie_pkg::ST_IDLE : mie_pkg::ST_WAIT;
      mie_pkg::ST_WAIT: next_state = (remain == 2'h1) ? mie_pkg::ST_IDLE : mie_pkg::ST_WAIT;
      default: next_state = mie_pkg::ST_IDLE;
    endcase
  end

  assign next_rd_wait = (accept && !hwrite) ? 1'b1 : (load_rd ? 1'b0 : rd_wait);
  // bus stalls while an instruction runs, so no register write races the execute cycle
  assign next_hreadyout = (next_state == mie_pkg::ST_IDLE) && !next_rd_wait;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= mie_pkg::ST_IDLE;
      remain <= 2'h0;
    end else begin
      state <= next_state;
      remain <= exec ? cyc_now - 2'h1 : (state == mie_pkg::ST_WAIT ? remain - 2'h1 : remain);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus pipeline

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      rd_wait <= 1'b0;
      pend_addr <= `MIE_RST_BYTE;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= `MIE_RST_WORD;
    end else begin
      if (accept) begin
        wr_pend <= hwrite;
        pend_addr <= haddr[7:0];
      end else if (hready) begin
        wr_pend <= 1'b0;
      end
      rd_wait <= next_rd_wait;
      hreadyout <= next_hreadyout;
      hresp <= 1'b0;
      if (load_rd) begin
        hrdata <= rd_val;
      end
    end
  end

  always_comb begin
    case (pend_addr)
      `MIE_OFS_CMD: rd_val = cmd_word;
      `MIE_OFS_STATUS: rd_val = {28'h0000000, last_cycles, skip_taken, state != mie_pkg::ST_IDLE};
      `MIE_OFS_ACC: rd_val = {24'h000000, accumulator_reg};
      `MIE_OFS_FLAGS: rd_val = {27'h0000000, flags};
      `MIE_OFS_IMM: rd_val = {24'h000000, imm_reg};
      `MIE_OFS_SECTION: rd_val = 32'(section_reg);
      `MIE_OFS_TBL_LOW: rd_val = {24'h000000, table_pointer_low};
      `MIE_OFS_TBL_HIGH: rd_val = 32'(table_pointer_high);
      `MIE_OFS_TBL_LATCH: rd_val = {24'h000000, table_high_latch};
      `MIE_OFS_DMEM_ADDR: rd_val = 32'(dmem_ptr);
      `MIE_OFS_DMEM_DATA: rd_val = {24'h000000, dmem[dmem_ptr]};
      `MIE_OFS_PMEM_ADDR: rd_val = 32'(pmem_ptr);
      `MIE_OFS_PMEM_DATA: rd_val = {16'h0000, pmem[pmem_ptr]};
      default: rd_val = `MIE_RST_WORD;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // architectural registers

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd_word <= `MIE_RST_WORD;
      accumulator_reg <= `MIE_RST_BYTE;
      imm_reg <= `MIE_RST_BYTE;
      section_reg <= '0;
      table_pointer_low <= `MIE_RST_BYTE;
      table_pointer_high <= '0;
      table_high_latch <= `MIE_RST_BYTE;
      dmem_ptr <= '0;
      pmem_ptr <= '0;
      skip_taken <= 1'b0;
      last_cycles <= 2'h0;
    end else begin
      if (wr_cmd) cmd_word <= hwdata;
      if (wr_imm) imm_reg <= hwdata[7:0];
      if (wr_sec) section_reg <= hwdata[DSEC_W-1:0];
      if (wr_thigh) table_pointer_high <= hwdata[TBH_W-1:0];
      if (wr_daddr) dmem_ptr <= hwdata[DA_W-1:0];
      if (wr_paddr) pmem_ptr <= hwdata[PA_W-1:0];
      if (exec && to_acc) accumulator_reg <= res;
      else if (wr_acc) accumulator_reg <= hwdata[7:0];
      if (exec && inc_tbl) table_pointer_low <= table_pointer_low_use;
      else if (wr_tlow) table_pointer_low <= hwdata[7:0];
      if (exec && tbl_op) table_high_latch <= pword[15:8];
      if (exec) begin
        skip_taken <= skip_now;
        last_cycles <= cyc_now;
      end
    end
  end

  // flags hold unless the instruction lists them
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags <= `MIE_RST_FLAGS;
    end else if (exec) begin
      if (upd_z || upd_arith) flags.zero_flag <= (res == 8'h00);
      if (upd_arith) begin
        flags.carry_flag <= sum9[8];
        flags.aux_carry_flag <= sum_lo[4];
        flags.overflow_flag <= add_ov;
        flags.signed_compare_flag <= add_sc;
      end
      if (upd_daa) flags.carry_flag <= daa_c;
    end else if (wr_flags) begin
      flags <= hwdata[4:0];
    end
  end

  // memories carry no reset
  always_ff @(posedge hclk) begin
    if (exec && to_mem) dmem[daddr] <= res;
    else if (wr_ddata) dmem[dmem_ptr] <= hwdata[7:0];
    if (wr_pdata) pmem[pmem_ptr] <= hwdata[15:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  sequence s_ext_skip;
    exec && skip_now && op_ext;
  endsequence

  sequence s_plain_skip;
    exec && skip_now && !op_ext && !tbl_op;
  endsequence

  a_copy_skip_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    (exec && cmd.op == mie_pkg::OP_COPY_SKIP_IF_ZERO) |=>
      (accumulator_reg == $past(mem_rd) && skip_taken == ($past(mem_rd) == 8'h00) && flags == $past(flags)))
    else $error("copy and skip mismatch");

  a_bit_skip_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    (exec && cmd.op == mie_pkg::OP_SKIP_IF_BIT_CLEAR) |=> (skip_taken == !$past(mem_bit) && flags == $past(flags)))
    else $error("bit skip mismatch");

  a_table_latch_split: assert property (@(posedge hclk) disable iff (!hresetn)
    (exec && tbl_op) |=> (table_high_latch == $past(pword[15:8]) && dmem[$past(daddr)] == $past(pword[7:0])))
    else $error("table word split wrong");

  a_table_inc_first: assert property (@(posedge hclk) disable iff (!hresetn)
    (exec && inc_tbl) |=> (table_pointer_low == $past(table_pointer_low) + 8'h01))
    else $error("table pointer not incremented");

  a_xor_zero_only: assert property (@(posedge hclk) disable iff (!hresetn)
    (exec && cmd.op == mie_pkg::OP_XOR_IMMEDIATE) |=>
      (accumulator_reg == ($past(accumulator_reg) ^ $past(imm_reg)) &&
       flags.zero_flag == (accumulator_reg == 8'h00) && flags.carry_flag == $past(flags.carry_flag)))
    else $error("xor result or flags wrong");

  a_add_carry_flags: assert property (@(posedge hclk) disable iff (!hresetn)
    (exec && cmd.op == mie_pkg::OP_EXT_ADD_WITH_CARRY && !cmd.dst_mem) |=>
      ({flags.carry_flag, accumulator_reg} ==
       {1'b0, $past(accumulator_reg)} + {1'b0, $past(mem_rd)} + {8'h00, $past(flags.carry_flag)}))
    else $error("add with carry sum wrong");

  a_clear_mem_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    (exec && cmd.op == mie_pkg::OP_EXT_CLEAR) |=> (dmem[$past(daddr)] == 8'h00 && flags == $past(flags)))
    else $error("clear left data or flags");

  a_daa_carry_only: assert property (@(posedge hclk) disable iff (!hresetn)
    (exec && cmd.op == mie_pkg::OP_EXT_DECIMAL_ADJUST) |=>
      (flags.zero_flag == $past(flags.zero_flag) && flags.overflow_flag == $past(flags.overflow_flag) &&
       accumulator_reg == $past(accumulator_reg)))
    else $error("decimal adjust touched more than carry");

  a_move_no_flags: assert property (@(posedge hclk) disable iff (!hresetn)
    (exec && cmd.op == mie_pkg::OP_EXT_MOVE_TO_ACC) |=> (accumulator_reg == $past(mem_rd) && flags == $past(flags)))
    else $error("move changed flags or missed data");

  a_ext_skip_three: assert property (@(posedge hclk) disable iff (!hresetn)
    s_ext_skip |=> (state == mie_pkg::ST_WAIT) [*2] ##1 (state == mie_pkg::ST_IDLE))
    else $error("extended skip not three cycles");

  a_plain_skip_two: assert property (@(posedge hclk) disable iff (!hresetn)
    s_plain_skip |=> (state == mie_pkg::ST_WAIT) ##1 (state == mie_pkg::ST_IDLE))
    else $error("ordinary skip not two cycles");

endmodule : mie_execute

// ==== tb/mie_execute_bench.sv ====
// self-checking bench of the execute block driven over its bus
`timescale 1ns/1ps
`include "mie_consts.svh"

module mie_execute_bench;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [31:0] rd;
  int n_mismatch = 0;
  int comparisons = 0;
  logic [7:0] av [2] = '{8'h9C, 8'h7F};
  logic [7:0] mv [2] = '{8'h64, 8'h01};
  logic [7:0] iv [2] = '{8'h9C, 8'h3C};
  logic [4:0] fv [2] = '{5'h01, 5'h1E};
  logic [2:0] bv [2] = '{3'h2, 3'h0};

  always #12.5 hclk = ~hclk;

  mie_execute #(.DSEC_W(1), .TBH_W(4)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_sim

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : cmp

  // entered just after a rising edge; bus hready is the slave's own
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    cmp({31'h0, hresp}, 32'h0, "resp");
  endtask : xfer

  function automatic logic [31:0] mk(input logic [4:0] op, input logic d, input logic x, input logic [2:0] b,
      input logic [7:0] o, input logic s);
    return {13'h0, s, o, b, x, d, op};
  endfunction : mk

  // expected {acc, mem, flags} after one operation
  function automatic logic [20:0] model(input logic [4:0] op, input logic d, input logic [7:0] a,
      input logic [7:0] m, input logic [7:0] imm, input logic [4:0] f, input logic [2:0] b);
    logic [7:0] r;
    logic [8:0] s;
    logic [4:0] n;
    logic wm;
    logic ci;
    logic lo;
    logic hi;
    logic ov;
    n = f;
    ci = (op == 5'h09) ? f[0] : 1'b0;
    lo = (a[3:0] > `MIE_NIBBLE_MAX) || f[1];
    hi = (a[7:4] > `MIE_NIBBLE_MAX) || f[0];
    s = (op == 5'h10) ? {1'b0, a} + {1'b0, (hi ? `MIE_DAA_HI : 8'h00) | (lo ? `MIE_DAA_LO : 8'h00)}
      : {1'b0, a} + {1'b0, m} + {8'h00, ci};
    ov = s[7] ^ a[7] ^ m[7] ^ s[8];
    wm = (op inside {5'h07, 5'h0D, 5'h0E, 5'h10, 5'h14}) || (d && op inside {[5'h09:5'h12]});
    case (op)
      5'h06, 5'h07: r = a ^ m;
      5'h08: r = a ^ imm;
      5'h09, 5'h0A, 5'h10: r = s[7:0];
      5'h0B: r = a & m;
      5'h0C: r = a | m;
      5'h0D: r = 8'h00;
      5'h0E: r = m & ~(8'h01 << b);
      5'h0F: r = ~m;
      5'h11: r = m - 8'h01;
      5'h12: r = m + 8'h01;
      5'h13: r = m;
      default: r = a;
    endcase
    if (!(op inside {5'h0D, 5'h0E, 5'h10, 5'h13, 5'h14})) n[2] = (r == 8'h00);
    if (op inside {5'h09, 5'h0A}) n = {ov ^ s[7], ov, s[7:0] == 8'h00, a[4] ^ m[4] ^ s[4], s[8]};
    if (op == 5'h10) n[0] = f[0] | hi | s[8];
    return {wm ? a : r, wm ? r : m, n};
  endfunction : model

  task automatic put(input logic [7:0] a, input logic [4:0] f, input logic [7:0] i, input logic [8:0] da,
      input logic [7:0] m);
    xfer(1'b1, `MIE_OFS_ACC, {24'h0, a});
    xfer(1'b1, `MIE_OFS_FLAGS, {27'h0, f});
    xfer(1'b1, `MIE_OFS_IMM, {24'h0, i});
    xfer(1'b1, `MIE_OFS_SECTION, 32'h0);
    xfer(1'b1, `MIE_OFS_DMEM_ADDR, {23'h0, da});
    xfer(1'b1, `MIE_OFS_DMEM_DATA, {24'h0, m});
  endtask : put

  task automatic post(input logic [20:0] e);
    xfer(1'b0, `MIE_OFS_ACC, 32'h0);
    cmp(rd, {24'h0, e[20:13]}, "acc");
    xfer(1'b0, `MIE_OFS_FLAGS, 32'h0);
    cmp(rd, {27'h0, e[4:0]}, "flags");
    xfer(1'b0, `MIE_OFS_DMEM_DATA, 32'h0);
    cmp(rd, {24'h0, e[12:5]}, "mem");
  endtask : post

  ////////////////////////////////////////////////////////////////////////////////
  // st is {cycles, skip}
  task automatic sk(input logic [4:0] op, input logic x, input logic [7:0] m, input logic [2:0] b,
      input logic [2:0] st);
    put(8'hAA, 5'h15, 8'h00, {x, 8'h12}, m);
    xfer(1'b1, `MIE_OFS_CMD, mk(op, 1'b0, x, b, 8'h12, x));
    xfer(1'b0, `MIE_OFS_STATUS, 32'h0);
    cmp(rd, {28'h0, st, 1'b0}, "status");
    post({(op == 5'h00) ? m : 8'hAA, m, 5'h15});
  endtask : sk

  task automatic tbl(input logic [4:0] op, input logic [11:0] pa, input logic [7:0] lo);
    xfer(1'b1, `MIE_OFS_TBL_LOW, 32'h3F);
    xfer(1'b1, `MIE_OFS_TBL_HIGH, 32'h3);
    xfer(1'b1, `MIE_OFS_PMEM_ADDR, {20'h0, pa});
    // per-op word so a wrong page or pointer reads a stale word
    xfer(1'b1, `MIE_OFS_PMEM_DATA, {16'h0, 3'h6, op, 3'h2, op});
    put(8'h11, 5'h0A, 8'h00, 9'h033, 8'hEE);
    xfer(1'b1, `MIE_OFS_CMD, mk(op, 1'b0, 1'b0, 3'h0, 8'h33, 1'b1));
    xfer(1'b0, `MIE_OFS_TBL_LATCH, 32'h0);
    cmp(rd, {24'h0, 3'h6, op}, "latch");
    xfer(1'b0, `MIE_OFS_TBL_LOW, 32'h0);
    cmp(rd, {24'h0, lo}, "pointer");
    post({8'h11, 3'h2, op, 5'h0A});
  endtask : tbl

  task automatic t_alu;
    logic [20:0] e;
    for (int v = 0; v < 2; v++) begin
      for (int op = 6; op <= 20; op++) begin
        for (int d = 0; d < 2; d++) begin
          put(av[v], fv[v], iv[v], {op >= 9, 8'h47}, mv[v]);
          xfer(1'b1, `MIE_OFS_CMD, mk(op[4:0], d[0], 1'b0, bv[v], 8'h47, 1'b1));
          e = model(op[4:0], d[0], av[v], mv[v], iv[v], fv[v], bv[v]);
          post(e);
        end
      end
    end
  endtask : t_alu

  // reset value of a register and an unmapped offset that must read zero
  task automatic t_map;
    xfer(1'b0, `MIE_OFS_ACC, 32'h0);
    cmp(rd, {24'h0, `MIE_RST_BYTE}, "reset acc");
    xfer(1'b1, 8'h3C, 32'hFFFF_FFFF);
    xfer(1'b0, 8'h3C, 32'h0);
    cmp(rd, 32'h0, "unmapped");
  endtask : t_map

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_map();
    sk(5'h00, 1'b0, 8'h00, 3'h0, 3'b101);
    sk(5'h00, 1'b0, 8'h5A, 3'h0, 3'b010);
    sk(5'h01, 1'b0, 8'hF7, 3'h3, 3'b101);
    sk(5'h01, 1'b0, 8'h08, 3'h3, 3'b010);
    sk(5'h01, 1'b1, 8'hFE, 3'h0, 3'b111);
    sk(5'h00, 1'b1, 8'h00, 3'h0, 3'b111);
    sk(5'h01, 1'b1, 8'h01, 3'h0, 3'b100);
    tbl(5'h02, 12'h33F, 8'h3F);
    tbl(5'h03, 12'hF3F, 8'h3F);
    tbl(5'h04, 12'h340, 8'h40);
    tbl(5'h05, 12'hF40, 8'h40);
    t_alu();
    end_sim();
  end

  // whole run is about two thousand cycles; twenty times that means a hang
  initial begin
    repeat (40000) @(posedge hclk);
    n_mismatch++;
    end_sim();
  end
endmodule : mie_execute_bench
